/* File: isc_consts.svh */
/*
 interrupt status collector constants: offsets, bit positions, reset values.
 assumes inclusion by the design file and the bench, not by isc_pkg.sv.
*/
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH
`define ISC_OFF_INTERRUPT_STATUS 8'h58
`define ISC_OFF_INT_EN 8'h5C
`define ISC_OFF_BYTE_TEST 8'h64
`define ISC_OFF_CTRL 8'h70
`define ISC_BYTE_TEST_VAL 32'h87654321
`define ISC_STS_RESET 32'h00000000
`define ISC_EN_RESET 32'h00000000
`define ISC_STS_MASK 32'h83BFE7DF
`define ISC_WC_MASK 32'h83BBE7DF
`define ISC_BIT_SW 31
`define ISC_BIT_TXSTOP 25
`define ISC_BIT_RXSTOP 24
`define ISC_BIT_DFH 23
`define ISC_BIT_TXIOC 21
`define ISC_BIT_RXDMA 20
`define ISC_BIT_TIMER 19
`define ISC_BIT_PHY 18
`define ISC_BIT_PWR 17
`define ISC_BIT_TRANSMIT_STATUS_OVERFLOW_FLAG 16
`define ISC_BIT_RWT 15
`define ISC_BIT_RXE 14
`define ISC_BIT_TXE 13
`define ISC_BIT_TRANSMIT_DATA_OVERRUN_FLAG 10
`define ISC_BIT_TRANSMIT_SPACE_AVAILABLE_FLAG 9
`define ISC_BIT_TRANSMIT_STATUS_FULL_FLAG 8
`define ISC_BIT_TRANSMIT_STATUS_LEVEL_FLAG 7
`define ISC_BIT_RXDF 6
`define ISC_BIT_RECEIVE_STATUS_FULL_FLAG 4
`define ISC_BIT_RECEIVE_STATUS_LEVEL_FLAG 3
`define ISC_BIT_CTRL_SWEN 0
`define ISC_RESP_OKAY 2'b00
`define ISC_RESP_SLVERR 2'b10
`endif

/* File: isc_pkg.sv */
/*
 interrupt status collector types.
 assumes isc_consts.svh is on the include path.
*/
package isc_pkg;
  typedef struct packed {
    logic tx_halted;
    logic rx_halted;
    logic drop_cnt_msb;
    logic transmit_completion_flag_loaded;
    logic rx_dma_done;
    logic timer_wrap;
    logic phy_irq;
    logic power_event;
    logic tx_status_ovf;
    logic rx_long_packet;
    logic rx_error;
    logic tx_error;
    logic tx_data_write_full;
    logic tx_space_over_level;
    logic tx_status_full;
    logic tx_status_level;
    logic rx_frame_dropped;
    logic rx_status_full;
    logic rx_status_level;
    logic [2:0] io_line_events;
  } isc_src_t;
  typedef enum logic [1:0] {
    ISC_WR_IDLE = 2'b00,
    ISC_WR_RESP = 2'b01
  } isc_wr_state_t;
endpackage

/* File: isc_collector.sv */
/*
 interrupt status collector: status, enable, control registers over axi4-lite.
 assumes event sources are synchronous to ref_clk_i and give one-cycle or level pulses.
*/
`timescale 1ns/1ns
`include "isc_consts.svh"

// What this block does
// - writing one clears a status flag
// - software enable high sets bit 31
// - stop requested and halted sets bit 25
// - receive halt sets bit 24
// - drop counter msb rising sets bit 23
// - completion-marked buffer loaded sets bit 21
// - receive dma count moved sets bit 20
// - timer wrap to max sets bit 19
// - bit 18 read-only phy event
// - power event sets bit 17, clearable
// - wake only on byte test write
// - power interrupt bypasses deassertion timer
// - status fifo overflow sets bit 16
// - packet over 2048 bytes sets bit 15
// - receive error sets bit 14
// - transmit error sets bit 13
// - write to full fifo sets bit 10
// - free space over threshold sets bit 9
// - status fifo full sets bits 8, 4
// - status level reached sets bits 7, 3
// - dropped frame sets bit 6
// - bits 2..0 are io line flags
// - enable masks output, not status
// - master indication when any enabled flag
module isc_collector (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // event sources
  input wire isc_pkg::isc_src_t src_i,
  input wire logic tx_stop_request_i,
  // low power state and outputs
  input wire logic low_power_i,
  output logic wake_o,
  output logic master_irq_o,
  output logic power_irq_o,
  output logic software_irq_enable_o
);
  import isc_pkg::*;

  logic [31:0] status_q, status_d;
  logic [31:0] enable_q;
  logic software_irq_enable_q;
  logic drop_msb_q, timer_wrap_q;
  logic aw_held_q, w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  isc_wr_state_t wr_state_q;
  logic bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wake_q, master_q, power_q;

  // write path decode
  wire aw_fire = s_axi_awvalid_i & awready_q;
  wire w_fire = s_axi_wvalid_i & wready_q;
  wire wr_go = (wr_state_q == ISC_WR_IDLE) & aw_held_q & w_held_q;
  wire [31:0] byte_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wr_bits = w_data_q & byte_mask;
  wire hit_sts = aw_addr_q == `ISC_OFF_INTERRUPT_STATUS;
  wire hit_en = aw_addr_q == `ISC_OFF_INT_EN;
  wire hit_bt = aw_addr_q == `ISC_OFF_BYTE_TEST;
  wire hit_ctrl = aw_addr_q == `ISC_OFF_CTRL;
  wire wr_known = hit_sts | hit_en | hit_bt | hit_ctrl;
  wire [31:0] clear_mask = (wr_go & hit_sts) ? (wr_bits & `ISC_WC_MASK) : 32'h00000000;

  // read path decode
  wire ar_fire = s_axi_arvalid_i & arready_q;
  wire rd_sts = s_axi_araddr_i == `ISC_OFF_INTERRUPT_STATUS;
  wire rd_en = s_axi_araddr_i == `ISC_OFF_INT_EN;
  wire rd_bt = s_axi_araddr_i == `ISC_OFF_BYTE_TEST;
  wire rd_ctrl = s_axi_araddr_i == `ISC_OFF_CTRL;
  wire rd_known = rd_sts | rd_en | rd_bt | rd_ctrl;
  wire [31:0] rd_mux = rd_sts ? status_q : rd_en ? (enable_q & `ISC_STS_MASK) : rd_bt ? `ISC_BYTE_TEST_VAL
    : rd_ctrl ? {31'h0, software_irq_enable_q} : 32'h00000000;

  // event set vector
  logic [31:0] set_v;
  always_comb begin
    set_v = 32'h00000000;
    set_v[`ISC_BIT_SW] = software_irq_enable_q;
    set_v[`ISC_BIT_TXSTOP] = tx_stop_request_i & src_i.tx_halted;
    set_v[`ISC_BIT_RXSTOP] = src_i.rx_halted;
    set_v[`ISC_BIT_DFH] = src_i.drop_cnt_msb & ~drop_msb_q;
    set_v[`ISC_BIT_TXIOC] = src_i.transmit_completion_flag_loaded;
    set_v[`ISC_BIT_RXDMA] = src_i.rx_dma_done;
    set_v[`ISC_BIT_TIMER] = src_i.timer_wrap & ~timer_wrap_q;
    set_v[`ISC_BIT_PWR] = src_i.power_event;
    set_v[`ISC_BIT_TRANSMIT_STATUS_OVERFLOW_FLAG] = src_i.tx_status_ovf;
    set_v[`ISC_BIT_RWT] = src_i.rx_long_packet;
    set_v[`ISC_BIT_RXE] = src_i.rx_error;
    set_v[`ISC_BIT_TXE] = src_i.tx_error;
    set_v[`ISC_BIT_TRANSMIT_DATA_OVERRUN_FLAG] = src_i.tx_data_write_full;
    set_v[`ISC_BIT_TRANSMIT_SPACE_AVAILABLE_FLAG] = src_i.tx_space_over_level;
    set_v[`ISC_BIT_TRANSMIT_STATUS_FULL_FLAG] = src_i.tx_status_full;
    set_v[`ISC_BIT_RECEIVE_STATUS_FULL_FLAG] = src_i.rx_status_full;
    set_v[`ISC_BIT_TRANSMIT_STATUS_LEVEL_FLAG] = src_i.tx_status_level;
    set_v[`ISC_BIT_RECEIVE_STATUS_LEVEL_FLAG] = src_i.rx_status_level;
    set_v[`ISC_BIT_RXDF] = src_i.rx_frame_dropped;
    set_v[2:0] = src_i.io_line_events;
  end

  // sticky flags, set wins over clear; phy bit follows its source
  always_comb begin
    status_d = (set_v | (status_q & ~clear_mask)) & `ISC_STS_MASK;
    status_d[`ISC_BIT_PHY] = src_i.phy_irq;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= `ISC_STS_RESET;
      drop_msb_q <= 1'b0;
      timer_wrap_q <= 1'b0;
    end else begin
      status_q <= status_d;
      drop_msb_q <= src_i.drop_cnt_msb;
      timer_wrap_q <= src_i.timer_wrap;
    end
  end

  // enable and control registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_q <= `ISC_EN_RESET;
      software_irq_enable_q <= 1'b0;
    end else if (wr_go) begin
      if (hit_en)
        enable_q <= (enable_q & ~byte_mask) | (wr_bits & `ISC_STS_MASK);
      if (hit_ctrl & w_strb_q[0])
        software_irq_enable_q <= w_data_q[`ISC_BIT_CTRL_SWEN];
    end
  end

  // outputs: master indication, power interrupt, wake
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      master_q <= 1'b0;
      power_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      master_q <= |(status_d & enable_q);
      power_q <= status_d[`ISC_BIT_PWR] & enable_q[`ISC_BIT_PWR];
      wake_q <= wr_go & hit_bt & low_power_i;
    end
  end

  // write channel handshake
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      wr_state_q <= ISC_WR_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= `ISC_RESP_OKAY;
    end else begin
      awready_q <= ~aw_held_q & ~aw_fire & (wr_state_q == ISC_WR_IDLE);
      wready_q <= ~w_held_q & ~w_fire & (wr_state_q == ISC_WR_IDLE);
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      case (wr_state_q)
        ISC_WR_IDLE: begin
          if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? `ISC_RESP_OKAY : `ISC_RESP_SLVERR;
            wr_state_q <= ISC_WR_RESP;
          end
        end
        ISC_WR_RESP: begin
          if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
            wr_state_q <= ISC_WR_IDLE;
          end
        end
        default: begin
          wr_state_q <= ISC_WR_IDLE;
        end
      endcase
    end
  end

  // read channel handshake
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `ISC_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_q & ~ar_fire;
      if (ar_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_known ? `ISC_RESP_OKAY : `ISC_RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign wake_o = wake_q;
  assign master_irq_o = master_q;
  assign power_irq_o = power_q;
  assign software_irq_enable_o = software_irq_enable_q;

  // checks
  property p_clear_takes;
    @(posedge ref_clk_i) disable iff (rst_i)
      (wr_go && hit_sts && wr_bits[`ISC_BIT_TXE] && !set_v[`ISC_BIT_TXE]) |=> !status_q[`ISC_BIT_TXE];
  endproperty
  a_clear_takes: assert property (p_clear_takes) else $error("written one did not clear flag");

  property p_sw_set;
    @(posedge ref_clk_i) disable iff (rst_i)
      software_irq_enable_q |=> status_q[`ISC_BIT_SW];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software flag not set");

  property p_txstop;
    @(posedge ref_clk_i) disable iff (rst_i)
      (tx_stop_request_i && src_i.tx_halted) |=> status_q[`ISC_BIT_TXSTOP];
  endproperty
  a_txstop: assert property (p_txstop) else $error("transmit stop flag missing");

  property p_dfh;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(src_i.drop_cnt_msb) |-> ##1 status_q[`ISC_BIT_DFH];
  endproperty
  a_dfh: assert property (p_dfh) else $error("drop half flag missing");

  property p_phy_ro;
    @(posedge ref_clk_i) disable iff (rst_i)
      ##1 status_q[`ISC_BIT_PHY] == $past(src_i.phy_irq);
  endproperty
  a_phy_ro: assert property (p_phy_ro) else $error("phy bit not following source");

  property p_pwr_irq;
    @(posedge ref_clk_i) disable iff (rst_i)
      (src_i.power_event && enable_q[`ISC_BIT_PWR]) |=> power_irq_o && master_irq_o;
  endproperty
  a_pwr_irq: assert property (p_pwr_irq) else $error("power interrupt held off");

  property p_wake;
    @(posedge ref_clk_i) disable iff (rst_i)
      wake_o |-> $past(wr_go && hit_bt && low_power_i);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without byte test write");

  property p_master;
    @(posedge ref_clk_i) disable iff (rst_i)
      ##1 (master_irq_o == |(status_q & enable_q)) || $past(wr_go && hit_en);
  endproperty
  a_master: assert property (p_master) else $error("master indication mismatch");

  property p_reserved;
    @(posedge ref_clk_i) disable iff (rst_i)
      (status_q & ~`ISC_STS_MASK) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");

  property p_write_resp;
    @(posedge ref_clk_i) disable iff (rst_i)
      wr_go |=> s_axi_bvalid_o;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

  property p_rxstop;
    @(posedge ref_clk_i) disable iff (rst_i)
      src_i.rx_halted |=> status_q[`ISC_BIT_RXSTOP];
  endproperty
  a_rxstop: assert property (p_rxstop) else $error("receive stop flag missing");

  property p_timer;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(src_i.timer_wrap) |-> ##1 status_q[`ISC_BIT_TIMER];
  endproperty
  a_timer: assert property (p_timer) else $error("timer wrap flag missing");

  property p_pwr_flag;
    @(posedge ref_clk_i) disable iff (rst_i)
      src_i.power_event |=> status_q[`ISC_BIT_PWR];
  endproperty
  a_pwr_flag: assert property (p_pwr_flag) else $error("power event flag missing");

  property p_io_lines;
    @(posedge ref_clk_i) disable iff (rst_i)
      (src_i.io_line_events != 3'h0) |=> (status_q[2:0] & $past(src_i.io_line_events)) == $past(src_i.io_line_events);
  endproperty
  a_io_lines: assert property (p_io_lines) else $error("io line flag missing");

  property p_zero_keeps;
    @(posedge ref_clk_i) disable iff (rst_i)
      (wr_go && hit_sts && !wr_bits[`ISC_BIT_RXE] && status_q[`ISC_BIT_RXE]) |=> status_q[`ISC_BIT_RXE];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("written zero cleared flag");
endmodule

/* File: isc_host.sv */
/*
 host model: axi4-lite master issuing single reads and writes.
 assumes the slave answers within 40 cycles; stuck_o flags a hang.
*/
`timescale 1ns/1ns
module isc_host (
  // clock
  input wire logic ref_clk_i,
  // write channels
  output logic [7:0] s_axi_awaddr_i = '0,
  output logic s_axi_awvalid_i = 1'b0,
  input wire logic s_axi_awready_o,
  output logic [31:0] s_axi_wdata_i = '0,
  output logic [3:0] s_axi_wstrb_i = 4'hF,
  output logic s_axi_wvalid_i = 1'b0,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  output logic s_axi_bready_i = 1'b0,
  // read channels
  output logic [7:0] s_axi_araddr_i = '0,
  output logic s_axi_arvalid_i = 1'b0,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  output logic s_axi_rready_i = 1'b0,
  // hang flag
  output logic stuck_o = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o && n < 40);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (n >= 40) stuck_o <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o && n < 40);
    v = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    if (n >= 40) stuck_o <= 1'b1;
  endtask
endmodule

/* File: isc_collector_bench.sv */
/*
 self-checking bench for the interrupt status collector.
 assumes isc_host drives the register bus and isc_consts.svh is on the path.
*/
`timescale 1ns/1ns
`include "isc_consts.svh"
module isc_collector_bench;
  import isc_pkg::*;
  localparam logic [31:0] VALID = 32'h83BFE7DF;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d, en;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, stuck_o;
  isc_src_t src_i = '0;
  logic tx_stop_request_i = 1'b1;
  logic low_power_i = 1'b1;
  logic wake_o, master_irq_o, power_irq_o, software_irq_enable_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_wake = 0;
  int sb[22] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 13, 14, 15, 16, 17, 18, 19, 20, 21, 23, 24, 25};

  isc_collector isc_collector_i (.*);
  isc_host isc_host_i (.*);

  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (wake_o === 1'b1) n_wake <= n_wake + 1;
  always @(posedge stuck_o) begin
    n_mismatch++;
    final_report();
  end

  // flag expected from source i; the phy mirror has dropped once its source is gone
  function automatic logic [31:0] flag(int i);
    return (i == 15) ? 32'h0 : (32'h1 << sb[i]);
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] v);
    isc_host_i.wr(a, v, r);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    isc_host_i.rd(a, d, r);
    chk(nm, e, d);
  endtask

  task automatic pulse(input logic [21:0] v);
    @(posedge ref_clk_i);
    src_i <= isc_src_t'(v);
    @(posedge ref_clk_i);
    src_i <= '0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hB614));
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rc("status reset", `ISC_OFF_INTERRUPT_STATUS, 32'h0);
    rc("enable reset", `ISC_OFF_INT_EN, 32'h0);
    rc("byte test", `ISC_OFF_BYTE_TEST, 32'h87654321);
    en = $urandom;
    w(`ISC_OFF_INT_EN, en);
    chk("write resp", 32'h0, {30'h0, r});
    rc("enable rw", `ISC_OFF_INT_EN, en & VALID);
    for (int i = 0; i < 22; i++) begin
      pulse(22'h1 << i);
      rc("flag set", `ISC_OFF_INTERRUPT_STATUS, flag(i));
      chk("master irq", {31'h0, |(flag(i) & en)}, {31'h0, master_irq_o});
      chk("power irq", {31'h0, (sb[i] == 17) & en[17]}, {31'h0, power_irq_o});
      w(`ISC_OFF_INTERRUPT_STATUS, ~flag(i));
      rc("flag latched", `ISC_OFF_INTERRUPT_STATUS, flag(i));
      w(`ISC_OFF_INTERRUPT_STATUS, flag(i));
      rc("flag cleared", `ISC_OFF_INTERRUPT_STATUS, 32'h0);
      chk("master drop", 32'h0, {31'h0, master_irq_o});
    end
    chk("no wake on event", 32'h0, n_wake);
    w(`ISC_OFF_BYTE_TEST, $urandom);
    repeat (2) @(posedge ref_clk_i);
    chk("wake pulse", 32'h1, n_wake);
    low_power_i <= 1'b0;
    w(`ISC_OFF_BYTE_TEST, $urandom);
    repeat (2) @(posedge ref_clk_i);
    chk("no wake when awake", 32'h1, n_wake);
    tx_stop_request_i <= 1'b0;
    pulse(22'h1 << 21);
    rc("halt without stop", `ISC_OFF_INTERRUPT_STATUS, 32'h0);
    @(posedge ref_clk_i);
    src_i.phy_irq <= 1'b1;
    w(`ISC_OFF_INTERRUPT_STATUS, 32'hFFFFFFFF);
    rc("phy read only", `ISC_OFF_INTERRUPT_STATUS, 32'h1 << 18);
    @(posedge ref_clk_i);
    src_i.phy_irq <= 1'b0;
    w(`ISC_OFF_CTRL, 32'h1);
    chk("sw enable", 32'h1, {31'h0, software_irq_enable_o});
    w(`ISC_OFF_CTRL, 32'h0);
    rc("sw flag", `ISC_OFF_INTERRUPT_STATUS, 32'h1 << 31);
    w(`ISC_OFF_INTERRUPT_STATUS, 32'h1 << 31);
    rc("sw cleared", `ISC_OFF_INTERRUPT_STATUS, 32'h0);
    w(8'h60, 32'hFFFFFFFF);
    chk("unmapped resp", 32'h2, {30'h0, r});
    rc("unmapped read", 8'h60, 32'h0);
    chk("unmapped read resp", 32'h2, {30'h0, r});
    final_report();
  end
endmodule
